//--- actc_pkg.sv
// package for the audio clock tree configuration block
// assumes a byte-wide register port driven by the control interface logic
package actc_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_SRC_A = 8'h32;
    localparam logic [7:0] ADDR_SRC_B = 8'h33;
    localparam logic [7:0] ADDR_NM_SRC = 8'h34;
    localparam logic [7:0] ADDR_PRESCALE = 8'h35;
    localparam logic [7:0] ADDR_MULT_HI = 8'h36;
    localparam logic [7:0] ADDR_FRAC_LO = 8'h37;
    localparam logic [7:0] ADDR_INT_LO = 8'h38;
    localparam logic [7:0] ADDR_N_PDM = 8'h39;
    localparam logic [7:0] ADDR_M_ADC = 8'h3a;
    localparam logic [7:0] ADDR_DAC_BH = 8'h3b;
    localparam logic [3:0] NUM_REGS = 4'ha;
    // reset values
    localparam logic [7:0] RST_SRC_A = 8'h00;
    localparam logic [7:0] RST_SRC_B = 8'h00;
    localparam logic [7:0] RST_NM_SRC = 8'h10;
    localparam logic [7:0] RST_PRESCALE = 8'h01;
    localparam logic [7:0] RST_MULT_HI = 8'h00;
    localparam logic [7:0] RST_FRAC_LO = 8'h00;
    localparam logic [7:0] RST_INT_LO = 8'h08;
    localparam logic [7:0] RST_N_PDM = 8'h20;
    localparam logic [7:0] RST_M_ADC = 8'h04;
    localparam logic [7:0] RST_DAC_BH = 8'h00;
    // writable bit masks, reserved bits read zero
    localparam logic [7:0] WMASK_SRC_A = 8'hf8;
    localparam logic [7:0] WMASK_SRC_B = 8'h70;
    localparam logic [7:0] WMASK_NM_SRC = 8'hf0;
    localparam logic [7:0] WMASK_FULL = 8'hff;
    localparam logic [7:0] WMASK_N_PDM = 8'hfc;
    localparam logic [7:0] WMASK_DAC_BH = 8'h36;
    // field positions
    localparam int PRE_SRC_LSB = 6;
    localparam int PBCLK_SRC_LSB = 3;
    localparam int SBCLK_SRC_LSB = 4;
    localparam int DIG_NM_LSB = 6;
    localparam int ANA_NM_LSB = 4;
    localparam int INT_HI_BIT = 7;
    localparam int HALVE_BIT = 6;
    localparam int FRAC_HI_LSB = 0;
    localparam int N_LSB = 5;
    localparam int PDM_LSB = 2;
    localparam int M_LSB = 2;
    localparam int ADC_MOD_LSB = 0;
    localparam int DAC_MOD_LSB = 4;
    localparam int PBDIV_HI_BIT = 2;
    localparam int SBDIV_HI_BIT = 1;
    // effective values for a zero code, and the largest valid fraction
    localparam logic [8:0] PRESCALE_ZERO_DIV = 9'h100;
    localparam logic [3:0] N_ZERO_DIV = 4'h8;
    localparam logic [6:0] M_ZERO_DIV = 7'h40;
    localparam logic [13:0] FRAC_MAX = 14'h270f;
    // clock source selector, one-hot over candidate sources
    typedef enum logic [6:0] {
        ACTC_SRC_NONE = 7'h00,
        ACTC_SRC_PBCLK = 7'h01,
        ACTC_SRC_SBCLK = 7'h02,
        ACTC_SRC_CTRL = 7'h04,
        ACTC_SRC_OSC = 7'h08,
        ACTC_SRC_LOOP = 7'h10,
        ACTC_SRC_DSP = 7'h20,
        ACTC_SRC_PBCLK_LJ = 7'h40
    } actc_src_t;
    // register port request
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } actc_req_t;
    // decoded settings handed to the analog/clock fabric
    typedef struct packed {
        actc_src_t prescale_src;
        actc_src_t pbclk_div_src;
        actc_src_t sbclk_div_src;
        actc_src_t dig_nm_src;
        actc_src_t ana_nm_src;
        logic [8:0] prescale_div;
        logic [8:0] int_mult;
        logic [13:0] frac_mult;
        logic halve;
        logic [3:0] n_div;
        logic [4:0] density_mod_divide_value;
        logic [6:0] m_div;
        logic [2:0] adc_mod_div;
        logic [2:0] dac_mod_div;
        logic pbdiv_high;
        logic sbdiv_high;
    } actc_cfg_t;
endpackage

//--- actc_clock_config.sv
// clock tree configuration registers and decoded divider/source settings
// assumes a byte register port from the control interface and an auto-detect
// engine that supplies its own settings while detection is enabled
`timescale 1ns/1ps

// Overview of operation
// - prescaler source 0 primary bclk, 1 secondary, 2 controller clock, 3 oscillator
// - primary bclk divider source 0 loop,2 sec,3 ctrl,4 osc,5 dsp; others reserved
// - secondary bclk divider source 0 loop,1 pri,3 ctrl,4 osc,5 dsp; others reserved
// - digital nm source 0 primary, 1 secondary, 2 controller, 3 oscillator
// - analog nm source resets 1; 0,1 loop, 2 digital source, 3 primary low jitter
// - prescaler divides by value, zero means 256, resets to 1
// - auto detection overrides programmed prescaler, multiplier and divider values except the halving bit
// - integer multiplier nine bits, 1 to 511, zero reserved, low byte resets 8
// - halving bit set makes the loop divide its clock by two
// - density divider codes 0 to 4 give 1,2,4,8,16; 5 to 7 reserved
// - m divider in bits 7 to 2, zero means 64, resets to 1
// - adc modulator divider 0 by 1, 1 by 2, 2 by 4, 3 reserved
// - dac modulator divider bits 5 to 4, same codes, 3 reserved
// - bits 2 and 1 hold primary and secondary bclk divider high bits
module actc_clock_config (
    input wire logic clk,
    input wire logic rst_n,
    input wire actc_pkg::actc_req_t req,
    output logic [7:0] rdata,
    output logic rvalid,
    input wire logic auto_detect_en,
    input wire actc_pkg::actc_cfg_t auto_cfg,
    output actc_pkg::actc_cfg_t cfg,
    output logic frac_out_of_range,
    output logic int_mult_reserved
);
    logic [7:0] regs_reg [actc_pkg::NUM_REGS];
    actc_pkg::actc_cfg_t man_cfg;
    logic [3:0] idx;
    logic hit;

    // map an address to a register index
    function automatic logic [4:0] addr_decode(input logic [7:0] a);
        logic [4:0] r;
        r = 5'h10;
        unique case (a)
            actc_pkg::ADDR_SRC_A: r = 5'h00;
            actc_pkg::ADDR_SRC_B: r = 5'h01;
            actc_pkg::ADDR_NM_SRC: r = 5'h02;
            actc_pkg::ADDR_PRESCALE: r = 5'h03;
            actc_pkg::ADDR_MULT_HI: r = 5'h04;
            actc_pkg::ADDR_FRAC_LO: r = 5'h05;
            actc_pkg::ADDR_INT_LO: r = 5'h06;
            actc_pkg::ADDR_N_PDM: r = 5'h07;
            actc_pkg::ADDR_M_ADC: r = 5'h08;
            actc_pkg::ADDR_DAC_BH: r = 5'h09;
            default: r = 5'h10;
        endcase
        return r;
    endfunction

    // per-index writable mask
    function automatic logic [7:0] wmask(input logic [3:0] i);
        logic [7:0] m;
        m = actc_pkg::WMASK_FULL;
        unique case (i)
            4'h0: m = actc_pkg::WMASK_SRC_A;
            4'h1: m = actc_pkg::WMASK_SRC_B;
            4'h2: m = actc_pkg::WMASK_NM_SRC;
            4'h7: m = actc_pkg::WMASK_N_PDM;
            4'h9: m = actc_pkg::WMASK_DAC_BH;
            default: m = actc_pkg::WMASK_FULL;
        endcase
        return m;
    endfunction

    // per-index reset value
    function automatic logic [7:0] rst_val(input logic [3:0] i);
        logic [7:0] v;
        v = 8'h00;
        unique case (i)
            4'h0: v = actc_pkg::RST_SRC_A;
            4'h1: v = actc_pkg::RST_SRC_B;
            4'h2: v = actc_pkg::RST_NM_SRC;
            4'h3: v = actc_pkg::RST_PRESCALE;
            4'h4: v = actc_pkg::RST_MULT_HI;
            4'h5: v = actc_pkg::RST_FRAC_LO;
            4'h6: v = actc_pkg::RST_INT_LO;
            4'h7: v = actc_pkg::RST_N_PDM;
            4'h8: v = actc_pkg::RST_M_ADC;
            default: v = actc_pkg::RST_DAC_BH;
        endcase
        return v;
    endfunction

    // two-bit source code to plain clock inputs
    function automatic actc_pkg::actc_src_t four_way(input logic [1:0] c);
        actc_pkg::actc_src_t s;
        s = actc_pkg::ACTC_SRC_PBCLK;
        unique case (c)
            2'h0: s = actc_pkg::ACTC_SRC_PBCLK;
            2'h1: s = actc_pkg::ACTC_SRC_SBCLK;
            2'h2: s = actc_pkg::ACTC_SRC_CTRL;
            2'h3: s = actc_pkg::ACTC_SRC_OSC;
        endcase
        return s;
    endfunction

    // three-bit bclk divider source; own bclk code is reserved
    function automatic actc_pkg::actc_src_t bclk_src(input logic [2:0] c,
                                                     input logic primary);
        actc_pkg::actc_src_t s;
        s = actc_pkg::ACTC_SRC_NONE;
        unique case (c)
            3'h0: s = actc_pkg::ACTC_SRC_LOOP;
            3'h1: s = primary ? actc_pkg::ACTC_SRC_NONE : actc_pkg::ACTC_SRC_PBCLK;
            3'h2: s = primary ? actc_pkg::ACTC_SRC_SBCLK : actc_pkg::ACTC_SRC_NONE;
            3'h3: s = actc_pkg::ACTC_SRC_CTRL;
            3'h4: s = actc_pkg::ACTC_SRC_OSC;
            3'h5: s = actc_pkg::ACTC_SRC_DSP;
            default: s = actc_pkg::ACTC_SRC_NONE;
        endcase
        return s;
    endfunction

    // modulator divider code; zero ratio marks the idle reserved code
    function automatic logic [2:0] mod_div(input logic [1:0] c);
        logic [2:0] d;
        d = 3'h0;
        unique case (c)
            2'h0: d = 3'h1;
            2'h1: d = 3'h2;
            2'h2: d = 3'h4;
            2'h3: d = 3'h0;
        endcase
        return d;
    endfunction

    // address decode of the current request
    always_comb
    begin
        logic [4:0] d;
        d = addr_decode(req.addr);
        hit = ~d[4];
        idx = d[3:0];
    end

    // register storage; reserved bits held at zero
    generate
        for (genvar g = 0; g < actc_pkg::NUM_REGS; g++)
        begin : g_reg
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    regs_reg[g] <= rst_val(4'(g));
                else if (req.wr_en && hit && idx == 4'(g))
                    regs_reg[g] <= req.wdata & wmask(4'(g));
            end
        end
    endgenerate

    // mapped byte for a read; unmapped addresses read zero
    logic [7:0] rd_byte;
    always_comb
    begin
        rd_byte = 8'h00;
        for (int i = 0; i < int'(actc_pkg::NUM_REGS); i++)
            if (hit && idx == 4'(i))
                rd_byte = regs_reg[i];
    end

    // read data registered one cycle after the request
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end
        else
        begin
            rvalid <= req.rd_en;
            if (req.rd_en)
                rdata <= rd_byte;
        end
    end

    // register bytes under the names of their roles
    logic [7:0] src_a_byte;
    logic [7:0] src_b_byte;
    logic [7:0] nm_src_byte;
    logic [7:0] prescale_byte;
    logic [7:0] mult_hi_byte;
    logic [7:0] frac_lo_byte;
    logic [7:0] int_lo_byte;
    logic [7:0] n_pdm_byte;
    logic [7:0] m_adc_byte;
    logic [7:0] dac_bh_byte;
    // decoded programmed settings, one signal per field
    actc_pkg::actc_src_t prescale_src_dec;
    actc_pkg::actc_src_t pbclk_src_dec;
    actc_pkg::actc_src_t sbclk_src_dec;
    actc_pkg::actc_src_t dig_nm_src_dec;
    actc_pkg::actc_src_t ana_nm_src_dec;
    logic [8:0] prescale_full;
    logic [8:0] n_full;
    logic [8:0] m_full;
    logic [8:0] int_mult_dec;
    logic [13:0] frac_mult_dec;
    logic halve_dec;
    logic [4:0] pdm_dec;
    logic [2:0] adc_mod_dec;
    logic [2:0] dac_mod_dec;
    logic pbdiv_high_dec;
    logic sbdiv_high_dec;
    // programming error conditions before the auto gate
    logic frac_big;
    logic int_zero;

    // zero code selects the largest ratio of a divider field
    function automatic logic [8:0] zero_is_max(input logic [7:0] v, input logic [8:0] top);
        logic [8:0] q;
        q = {1'b0, v};
        if (v == 8'h00)
            q = top;
        return q;
    endfunction

    // density divider code to ratio; zero ratio marks a reserved code
    function automatic logic [4:0] density_div(input logic [2:0] c);
        logic [4:0] d;
        d = 5'h00;
        unique case (c)
            3'h0: d = 5'h01;
            3'h1: d = 5'h02;
            3'h2: d = 5'h04;
            3'h3: d = 5'h08;
            3'h4: d = 5'h10;
            default: d = 5'h00;
        endcase
        return d;
    endfunction

    // register array seen as named bytes
    assign src_a_byte = regs_reg[0];
    assign src_b_byte = regs_reg[1];
    assign nm_src_byte = regs_reg[2];
    assign prescale_byte = regs_reg[3];
    assign mult_hi_byte = regs_reg[4];
    assign frac_lo_byte = regs_reg[5];
    assign int_lo_byte = regs_reg[6];
    assign n_pdm_byte = regs_reg[7];
    assign m_adc_byte = regs_reg[8];
    assign dac_bh_byte = regs_reg[9];

    // source selects of the loop, bit-clock dividers and n/m chain
    always_comb
    begin
        prescale_src_dec = four_way(src_a_byte[actc_pkg::PRE_SRC_LSB +: 2]);
        pbclk_src_dec = bclk_src(src_a_byte[actc_pkg::PBCLK_SRC_LSB +: 3], 1'b1);
        sbclk_src_dec = bclk_src(src_b_byte[actc_pkg::SBCLK_SRC_LSB +: 3], 1'b0);
        dig_nm_src_dec = four_way(nm_src_byte[actc_pkg::DIG_NM_LSB +: 2]);
        ana_nm_src_dec = actc_pkg::ACTC_SRC_LOOP;
        unique case (nm_src_byte[actc_pkg::ANA_NM_LSB +: 2])
            2'h0, 2'h1: ana_nm_src_dec = actc_pkg::ACTC_SRC_LOOP;
            2'h2: ana_nm_src_dec = dig_nm_src_dec;
            2'h3: ana_nm_src_dec = actc_pkg::ACTC_SRC_PBCLK_LJ;
        endcase
    end

    // divide values; a zero code picks the largest ratio
    always_comb
    begin
        prescale_full = zero_is_max(prescale_byte, actc_pkg::PRESCALE_ZERO_DIV);
        n_full = zero_is_max({5'h00, n_pdm_byte[actc_pkg::N_LSB +: 3]},
                             {5'h00, actc_pkg::N_ZERO_DIV});
        m_full = zero_is_max({2'h0, m_adc_byte[actc_pkg::M_LSB +: 6]},
                             {2'h0, actc_pkg::M_ZERO_DIV});
    end

    // loop multiplier fields joined from their high and low bytes
    always_comb
    begin
        int_mult_dec = {mult_hi_byte[actc_pkg::INT_HI_BIT], int_lo_byte};
        frac_mult_dec = {mult_hi_byte[actc_pkg::FRAC_HI_LSB +: 6], frac_lo_byte};
        halve_dec = mult_hi_byte[actc_pkg::HALVE_BIT];
    end

    // ratio codes with reserved values mapped to an idle zero ratio
    always_comb
    begin
        pdm_dec = density_div(n_pdm_byte[actc_pkg::PDM_LSB +: 3]);
        adc_mod_dec = mod_div(m_adc_byte[actc_pkg::ADC_MOD_LSB +: 2]);
        dac_mod_dec = mod_div(dac_bh_byte[actc_pkg::DAC_MOD_LSB +: 2]);
        pbdiv_high_dec = dac_bh_byte[actc_pkg::PBDIV_HI_BIT];
        sbdiv_high_dec = dac_bh_byte[actc_pkg::SBDIV_HI_BIT];
    end

    // programmed settings gathered into the carrier struct
    always_comb
    begin
        man_cfg = '0;
        man_cfg.prescale_src = prescale_src_dec;
        man_cfg.pbclk_div_src = pbclk_src_dec;
        man_cfg.sbclk_div_src = sbclk_src_dec;
        man_cfg.dig_nm_src = dig_nm_src_dec;
        man_cfg.ana_nm_src = ana_nm_src_dec;
        man_cfg.prescale_div = prescale_full;
        man_cfg.int_mult = int_mult_dec;
        man_cfg.frac_mult = frac_mult_dec;
        man_cfg.halve = halve_dec;
        man_cfg.n_div = n_full[3:0];
        man_cfg.density_mod_divide_value = pdm_dec;
        man_cfg.m_div = m_full[6:0];
        man_cfg.adc_mod_div = adc_mod_dec;
        man_cfg.dac_mod_div = dac_mod_dec;
        man_cfg.pbdiv_high = pbdiv_high_dec;
        man_cfg.sbdiv_high = sbdiv_high_dec;
    end

    // auto detection takes over values; sources and halving stay programmed
    always_comb
    begin
        cfg = man_cfg;
        if (auto_detect_en)
        begin
            cfg.prescale_div = auto_cfg.prescale_div;
            cfg.int_mult = auto_cfg.int_mult;
            cfg.frac_mult = auto_cfg.frac_mult;
            cfg.n_div = auto_cfg.n_div;
            cfg.density_mod_divide_value = auto_cfg.density_mod_divide_value;
            cfg.m_div = auto_cfg.m_div;
            cfg.adc_mod_div = auto_cfg.adc_mod_div;
            cfg.dac_mod_div = auto_cfg.dac_mod_div;
            cfg.pbdiv_high = auto_cfg.pbdiv_high;
            cfg.sbdiv_high = auto_cfg.sbdiv_high;
        end
    end

    // status flags for programming errors
    assign frac_big = man_cfg.frac_mult > actc_pkg::FRAC_MAX;
    assign int_zero = man_cfg.int_mult == 9'h000;
    assign int_mult_reserved = ~auto_detect_en && int_zero;
    assign frac_out_of_range = ~auto_detect_en && frac_big;
endmodule

//--- actc_clock_config_assertions.sv
// port checks for the clock tree configuration block
// assumes the package is compiled first; bound to the block below
`timescale 1ns/1ps
module actc_clock_config_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire actc_pkg::actc_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire logic auto_detect_en,
    input wire actc_pkg::actc_cfg_t auto_cfg,
    input wire actc_pkg::actc_cfg_t cfg,
    input wire logic frac_out_of_range,
    input wire logic int_mult_reserved
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // write data of the previous edge
    logic [7:0] wd;
    always_ff @(posedge clk) wd <= req.wdata;
    // write taken, then values still programmed
    sequence s_set(logic [7:0] a);
        req.wr_en && req.addr == a ##1 !auto_detect_en;
    endsequence
    property p_rv;
        rvalid == $past(req.rd_en);
    endproperty
    a_rv: assert property (p_rv) else $error("read answer timing");
    property p_rsv;
        rvalid && $past(req.addr) == 8'h3b |-> (rdata & 8'hc9) == 8'h00;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits read");
    property p_pre;
        s_set(8'h35) |-> cfg.prescale_div == ((wd == 8'h00) ? 9'h100 : {1'b0, wd});
    endproperty
    a_pre: assert property (p_pre) else $error("prescale divide");
    property p_src;
        s_set(8'h32) |-> cfg.prescale_src == 7'h1 << wd[7:6];
    endproperty
    a_src: assert property (p_src) else $error("prescale source");
    property p_m;
        s_set(8'h3a) |-> cfg.m_div == ((wd[7:2] == 6'h0) ? 7'h40 : {1'b0, wd[7:2]});
    endproperty
    a_m: assert property (p_m) else $error("m divide");
    property p_pdm;
        s_set(8'h39) |-> cfg.density_mod_divide_value == ((wd[4:2] < 3'h5) ? 5'h1 << wd[4:2] : 5'h0);
    endproperty
    a_pdm: assert property (p_pdm) else $error("density divide");
    property p_auto;
        auto_detect_en |-> cfg.m_div == auto_cfg.m_div && cfg.int_mult == auto_cfg.int_mult;
    endproperty
    a_auto: assert property (p_auto) else $error("auto override");
    property p_frac;
        !auto_detect_en |-> frac_out_of_range == (cfg.frac_mult > 14'h270f);
    endproperty
    a_frac: assert property (p_frac) else $error("fraction flag");
    property p_intres;
        !auto_detect_en |-> int_mult_reserved == (cfg.int_mult == 9'h000);
    endproperty
    a_intres: assert property (p_intres) else $error("integer multiplier flag");
endmodule
bind actc_clock_config actc_clock_config_chk chk_u (.clk(clk), .rst_n(rst_n), .req(req),
    .rdata(rdata), .rvalid(rvalid), .auto_detect_en(auto_detect_en),
    .auto_cfg(auto_cfg), .cfg(cfg), .frac_out_of_range(frac_out_of_range),
    .int_mult_reserved(int_mult_reserved));

//--- test_audio_clock_tree_config.sv
// bench for the clock tree configuration block
// assumes the package and the bound checker are compiled before it
`timescale 1ns/1ps
module test_audio_clock_tree_config;
    logic clk;
    logic rst_n;
    logic auto_detect_en;
    logic [7:0] rdata;
    logic rvalid;
    logic frac_out_of_range;
    logic int_mult_reserved;
    actc_pkg::actc_req_t req;
    actc_pkg::actc_cfg_t auto_cfg;
    actc_pkg::actc_cfg_t cfg;
    int failures = 0;
    int tests_run = 0;
    logic [7:0] q[$];
    // register model, reset values, writable masks, sources per code
    logic [7:0] m[10];
    logic [7:0] rv[10] = '{8'h00,8'h00,8'h10,8'h01,8'h00,8'h00,8'h08,8'h20,8'h04,8'h00};
    logic [7:0] wm[10] = '{8'hf8,8'h70,8'hf0,8'hff,8'hff,8'hff,8'hff,8'hfc,8'hff,8'h36};
    logic [6:0] pb[8] = '{7'h10,7'h00,7'h02,7'h04,7'h08,7'h20,7'h00,7'h00};
    logic [6:0] sb[8] = '{7'h10,7'h01,7'h00,7'h04,7'h08,7'h20,7'h00,7'h00};
    logic [6:0] an[4] = '{7'h10,7'h10,7'h04,7'h40};
    actc_clock_config dut_u (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
        .rvalid(rvalid), .auto_detect_en(auto_detect_en), .auto_cfg(auto_cfg), .cfg(cfg),
        .frac_out_of_range(frac_out_of_range), .int_mult_reserved(int_mult_reserved));
    // 40 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e)
        begin
            failures++;
            $display("wrong value at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic summarize;
        $display("compares %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // one request per falling edge; a read notes its expected byte
    task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        bit h;
        @(negedge clk);
        req = {w, r, a, d};
        h = a >= 8'h32 && a <= 8'h3b;
        if (r)
            q.push_back(h ? m[a - 8'h32] : 8'h00);
        if (w && h)
            m[a - 8'h32] = d & wm[a - 8'h32];
    endtask
    // write, then let the taking edge land
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        op(1'b1, 1'b0, a, d);
        op(1'b0, 1'b0, 8'h00, 8'h00);
    endtask
    // read answers against the oldest note
    always @(negedge clk)
        if (rvalid === 1'b1)
            chk(rdata, (q.size() > 0) ? q.pop_front() : 8'hxx);
    // hang guard
    initial
    begin
        repeat (5000) @(posedge clk);
        failures++;
        summarize;
    end
    initial
    begin
        req = '0;
        auto_detect_en = 1'b0;
        auto_cfg = '0;
        rst_n = 1'b0;
        m = rv;
        void'($urandom(32'he4899d70));
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        // reset values and unmapped bytes around the map
        for (int k = 8'h30; k < 8'h3e; k++)
            op(1'b0, 1'b1, 8'(k), 8'h00);
        $display("reset test done");
        // every source, n, density and modulator code, prescaler and m codes 0 to 7, reserved ones included
        for (int k = 0; k < 8; k++)
        begin
            w(8'h32, {k[1:0], k[2:0], 3'h0});
            w(8'h33, {1'b0, k[2:0], 4'h0});
            w(8'h34, {k[1:0], k[1:0], 4'h0});
            w(8'h39, {k[2:0], k[2:0], 2'h0});
            w(8'h3a, {3'h0, k[2:0], k[1:0]});
            w(8'h3b, {2'h0, k[1:0], 4'h6});
            w(8'h35, 8'(k));
            chk(cfg.pbclk_div_src, pb[k]);
            chk(cfg.sbclk_div_src, sb[k]);
            chk(cfg.dig_nm_src, 7'h1 << k[1:0]);
            chk(cfg.ana_nm_src, an[k[1:0]]);
            chk(cfg.n_div, (k == 0) ? 4'h8 : 4'(k));
            chk({cfg.adc_mod_div, cfg.dac_mod_div}, {2{(k[1:0] == 2'h3) ? 3'h0 : 3'h1 << k[1:0]}});
            chk({cfg.pbdiv_high, cfg.sbdiv_high}, 2'h3);
            chk(cfg.prescale_src, 7'h1 << k[1:0]);
            chk(cfg.prescale_div, (k == 0) ? 9'h100 : 9'(k));
            chk(cfg.density_mod_divide_value, (k < 5) ? 5'h1 << k : 5'h00);
            chk(cfg.m_div, (k == 0) ? 7'h40 : 7'(k));
        end
        $display("code test done");
        // multiplier limits, fraction range and halving
        w(8'h36, 8'h67);
        w(8'h37, 8'h0f);
        w(8'h38, 8'hff);
        chk({frac_out_of_range, cfg.halve, cfg.int_mult}, {2'h1, 9'h0ff});
        chk(cfg.frac_mult, 14'h270f);
        w(8'h37, 8'h10);
        w(8'h36, 8'ha7);
        chk({frac_out_of_range, cfg.halve, cfg.int_mult}, {2'h2, 9'h1ff});
        chk(cfg.frac_mult, 14'h2710);
        w(8'h36, 8'h00);
        w(8'h38, 8'h00);
        chk({int_mult_reserved, cfg.int_mult}, 10'h200);
        $display("multiplier test done");
        // auto detection takes over the value fields
        auto_cfg = 92'({$urandom, $urandom, $urandom});
        auto_detect_en = 1'b1;
        w(8'h35, 8'h05);
        chk({cfg.prescale_div, cfg.n_div}, {auto_cfg.prescale_div, auto_cfg.n_div});
        chk({int_mult_reserved, cfg.pbdiv_high, cfg.halve}, {1'b0, auto_cfg.pbdiv_high, 1'b0});
        chk({cfg.m_div, cfg.int_mult}, {auto_cfg.m_div, auto_cfg.int_mult});
        chk({cfg.frac_mult, cfg.sbdiv_high}, {auto_cfg.frac_mult, auto_cfg.sbdiv_high});
        chk({cfg.density_mod_divide_value, cfg.adc_mod_div}, {auto_cfg.density_mod_divide_value, auto_cfg.adc_mod_div});
        chk({cfg.dac_mod_div, frac_out_of_range}, {auto_cfg.dac_mod_div, 1'b0});
        chk(cfg.prescale_src, 7'h08);
        auto_detect_en = 1'b0;
        $display("auto test done");
        // random back-to-back traffic, write and read may share a cycle
        repeat (300)
            op(1'($urandom), 1'($urandom), 8'($urandom_range(8'h3d, 8'h30)), 8'($urandom));
        op(1'b0, 1'b0, 8'h00, 8'h00);
        op(1'b0, 1'b0, 8'h00, 8'h00);
        chk(q.size(), 0);
        $display("random test done");
        summarize;
    end
endmodule
